// >>> rtl/flag_clear_exec.sv
// Execute unit: flag clears, counter clears, interrupt gate, decrement ops
// Operation
// - Divider clear zeroes only low four bits
// - Event clear by 8-bit mask, bit3 reserved
// - Mask bits 0-2 clear divider, timer0, port
// - Mask bits 4-7 clear pin, serial, timer1
// - Parameter bit3 selects watchdog clock Fosc/1024
// - Port status clear drops port change flag
// - Serial status clear drops all serial flags
// - Watchdog clear zeroes only low four bits
// - Decrement nibble into memory and result, flags
// - Disable op blocks interrupt acceptance
// - Skip variant skips next when result nonzero
// - Enable op restores interrupt acceptance
`timescale 1ns/1ps
module flag_clear_exec import exec_pkg::*; (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        instrValid,
    input  wire logic [15:0] instrWord,
    input  wire logic [7:0]  eventIn,
    input  wire logic [7:0]  busAddr,
    input  wire logic [31:0] busWrData,
    input  wire logic        busWr,
    input  wire logic        busRd,
    output logic [31:0]      busRdData,
    output logic [3:0]       workResultReg,
    output logic             carryBit,
    output logic             zeroBit,
    output logic             skipNext,
    output logic             opDone,
    output logic             intEnable,
    output logic             wdtSlowClk,
    output logic [7:0]       eventFlags,
    output logic             portChangeStatus,
    output logic [1:0]       serialPortStatus,
    output logic             wdtExpire,
    output logic             irq
);
    // ****************************************
    // Declarations
    // ****************************************
    exec_state_t        st;
    exec_state_t        nxt;
    decode_if           dec ();
    logic [3:0]         dataMem [0:MEM_DEPTH-1];
    logic [3:0]         memNib;
    logic [3:0]         decVal;
    logic               isDecOp;
    logic [7:0]         evfClrMask;
    logic [7:0]         evSet;
    logic [3:0]         irqSet;
    logic [DIV_W-1:0]   dividerZero;
    logic [WDT_W-1:0]   watchdogCounter;
    logic               divWrap;
    logic               wdtWrap;
    logic               slowTick;
    logic               wdtTick;
    logic               memWrEn;
    logic [31:0]        rdMux;

    // ****************************************
    // Decode and counters
    // ****************************************
    assign dec.word  = instrWord;
    assign dec.valid = instrValid;

    op_decoder u_dec (
        .dec (dec)
    );

    // Divider runs at the core rate; its taps make the slower enables
    low_clr_counter #(.W(DIV_W)) u_div (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .countEn (1'b1),
        .clrLow  (dec.op == OP_CLR_DIV),
        .value   (dividerZero),
        .wrap    (divWrap)
    );

    // Fosc/1024 tick from the low ten divider bits
    assign slowTick = (dividerZero[9:0] == SLOW_TAP);
    assign wdtTick  = st.wdtSlow ? slowTick : divWrap;

    low_clr_counter #(.W(WDT_W)) u_wdt (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .countEn (wdtTick),
        .clrLow  (dec.op == OP_CLR_WDT),
        .value   (watchdogCounter),
        .wrap    (wdtWrap)
    );

    // ****************************************
    // Data memory and decrement path
    // ****************************************
    assign memNib  = dataMem[dec.addr];
    assign decVal  = memNib - 4'h1;
    assign isDecOp = (dec.op == OP_DEC) || (dec.op == OP_DEC_SKIP_NONZERO);
    assign memWrEn = busWr && (busAddr == REG_MEM_DATA);

    // Instruction write wins over a software write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (isDecOp) begin
            dataMem[dec.addr] <= decVal;
        end else if (memWrEn) begin
            dataMem[st.memAddr] <= busWrData[3:0];
        end
    end

    // ****************************************
    // Event sources
    // ****************************************
    // Bit 3 has no source and no clear, so it can never rise
    assign evfClrMask = (dec.op == OP_CLR_EVF) ? (dec.imm & EVF_VALID) : 8'h00;
    assign evSet      = (eventIn | {7'h00, divWrap}) & EVF_VALID;

    // Unit's own interrupt causes
    assign irqSet[IRQ_SKIP]   = (dec.op == OP_DEC_SKIP_NONZERO) && (decVal != 4'h0);
    assign irqSet[IRQ_BORROW] = isDecOp && (memNib == 4'h0);
    assign irqSet[IRQ_WDT]    = wdtWrap;
    assign irqSet[IRQ_BADOP]  = (dec.op == OP_BAD);

    // ****************************************
    // Register read mux
    // ****************************************
    always_comb begin
        case (busAddr)
            REG_EVF:      rdMux = {24'h000000, st.evFlags};
            REG_STAT:     rdMux = {21'h000000, st.serStat, st.portChg, st.wdtSlow,
                                   st.intEn, st.zero, st.carry, st.acc};
            REG_IRQ_ST:   rdMux = {28'h0000000, st.irqSt};
            REG_IRQ_MASK: rdMux = {28'h0000000, st.irqMask};
            REG_MEM_ADDR: rdMux = {25'h0000000, st.memAddr};
            REG_MEM_DATA: rdMux = {28'h0000000, dataMem[st.memAddr]};
            REG_DIV:      rdMux = {18'h00000, dividerZero};
            REG_WDT:      rdMux = {14'h0000, watchdogCounter};
            default:      rdMux = 32'h00000000;
        endcase
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    // Sets always win over clears so no event is lost on a clear cycle
    always_comb begin
        nxt = st;
        nxt.skip      = 1'b0;
        nxt.done      = (dec.op != OP_NONE);
        nxt.wdtExpire = wdtWrap;
        nxt.rdata     = busRd ? rdMux : 32'h00000000;

        nxt.evFlags = (st.evFlags & ~evfClrMask) | evSet;

        case (dec.op)
            OP_CLR_PMF: begin
                nxt.wdtSlow = dec.imm[PMF_SLOW];
            end
            OP_CLR_PORT_CHANGE_STATUS: begin
                nxt.portChg = 1'b0;
            end
            OP_CLR_SERIAL_PORT_STATUS: begin
                nxt.serStat = 2'b00;
            end
            OP_IRQ_DISABLE_OP: begin
                nxt.intEn = 1'b0;
            end
            OP_EN_INT: begin
                nxt.intEn = 1'b1;
            end
            OP_DEC, OP_DEC_SKIP_NONZERO: begin
                nxt.acc   = decVal;
                nxt.carry = (memNib == 4'h0);
                nxt.zero  = (decVal == 4'h0);
                nxt.skip  = (dec.op == OP_DEC_SKIP_NONZERO) && (decVal != 4'h0);
            end
            default: begin
                nxt.acc = st.acc;
            end
        endcase

        // Status bits set after their own clears
        if (eventIn[EVF_PORT]) begin
            nxt.portChg = 1'b1;
        end
        if (eventIn[EVF_RX]) begin
            nxt.serStat[0] = 1'b1;
        end
        if (eventIn[EVF_TX]) begin
            nxt.serStat[1] = 1'b1;
        end

        // Register writes
        if (busWr && (busAddr == REG_IRQ_MASK)) begin
            nxt.irqMask = busWrData[3:0];
        end
        if (busWr && (busAddr == REG_MEM_ADDR)) begin
            nxt.memAddr = busWrData[6:0];
        end

        // Read clears status; a cause in the same cycle survives
        if (busRd && (busAddr == REG_IRQ_ST)) begin
            nxt.irqSt = irqSet;
        end else begin
            nxt.irqSt = st.irqSt | irqSet;
        end
        nxt.irq = |(nxt.irqSt & nxt.irqMask);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= '0;
            st.evFlags <= EVF_RST;
            st.acc     <= ACC_RST;
            st.irqMask <= MASK_RST;
            st.intEn   <= INT_EN_RST;
        end else begin
            st <= nxt;
        end
    end

    // Outputs straight from the state register
    assign busRdData        = st.rdata;
    assign workResultReg    = st.acc;
    assign carryBit         = st.carry;
    assign zeroBit          = st.zero;
    assign skipNext         = st.skip;
    assign opDone           = st.done;
    assign intEnable        = st.intEn;
    assign wdtSlowClk       = st.wdtSlow;
    assign eventFlags       = st.evFlags;
    assign portChangeStatus = st.portChg;
    assign serialPortStatus = st.serStat;
    assign wdtExpire        = st.wdtExpire;
    assign irq              = st.irq;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    evf_reserved_a: assert property (eventFlags[3] == 1'b0)
        else $error("Reserved event flag set");
    evf_clear_a: assert property ((dec.op == OP_CLR_EVF) ##1 1'b1 |->
        ((eventFlags & $past(dec.imm) & ~$past(evSet)) == 8'h00))
        else $error("Masked event flag not cleared");
    evf_keep_a: assert property ((dec.op == OP_CLR_EVF) |=>
        (((eventFlags & ~$past(dec.imm)) & $past(eventFlags)) == ($past(eventFlags) & ~$past(dec.imm))))
        else $error("Unmasked event flag lost");
    wdt_source_a: assert property ((dec.op == OP_CLR_PMF) |=>
        wdtSlowClk == $past(dec.imm[PMF_SLOW]) ##1 wdtSlowClk == $past(wdtSlowClk))
        else $error("Watchdog source select wrong");
    port_clear_a: assert property ((dec.op == OP_CLR_PORT_CHANGE_STATUS) && !eventIn[EVF_PORT]
        |=> !portChangeStatus)
        else $error("Port change flag not cleared");
    serial_clear_a: assert property ((dec.op == OP_CLR_SERIAL_PORT_STATUS) && !eventIn[EVF_RX]
        && !eventIn[EVF_TX] |=> serialPortStatus == 2'b00)
        else $error("Serial flags not cleared");
    dec_result_a: assert property (isDecOp |=>
        (workResultReg == 4'($past(memNib) - 4'h1)) && (dataMem[$past(dec.addr)] == workResultReg)
        && (zeroBit == (workResultReg == 4'h0)))
        else $error("Decrement result wrong");
    int_disable_a: assert property ((dec.op == OP_IRQ_DISABLE_OP) |=> !intEnable)
        else $error("Interrupts still enabled");
    skip_nonzero_a: assert property ((dec.op == OP_DEC_SKIP_NONZERO) |=>
        skipNext == (workResultReg != 4'h0) ##1 !skipNext || $past(dec.op == OP_DEC_SKIP_NONZERO))
        else $error("Skip decision wrong");
    int_enable_a: assert property ((dec.op == OP_EN_INT) |=> intEnable)
        else $error("Interrupts not enabled");
    single_cycle_a: assert property (instrValid |=> opDone ##0 $past(instrValid))
        else $error("Instruction not done in one cycle");
    irq_level_a: assert property (irq == |(st.irqSt & st.irqMask))
        else $error("Interrupt output mismatch");
endmodule

// >>> rtl/exec_pkg.sv
// Constants, types and register map of the flag-clear and decrement execute unit
package exec_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] REG_EVF      = 8'h00;
    localparam logic [7:0] REG_STAT     = 8'h04;
    localparam logic [7:0] REG_IRQ_ST   = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_MEM_ADDR = 8'h10;
    localparam logic [7:0] REG_MEM_DATA = 8'h14;
    localparam logic [7:0] REG_DIV      = 8'h18;
    localparam logic [7:0] REG_WDT      = 8'h1c;

    // ****************************************
    // Widths and field positions
    // ****************************************
    localparam int DIV_W     = 14;
    localparam int WDT_W     = 18;
    localparam int MEM_DEPTH = 128;
    localparam int EVF_PORT  = 2;
    localparam int EVF_RX    = 5;
    localparam int EVF_TX    = 6;
    localparam int PMF_SLOW  = 3;
    localparam int IRQ_SKIP  = 0;
    localparam int IRQ_BORROW = 1;
    localparam int IRQ_WDT   = 2;
    localparam int IRQ_BADOP = 3;
    localparam logic [7:0] EVF_VALID = 8'hf7;
    localparam logic [9:0] SLOW_TAP  = 10'h3ff;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] EVF_RST    = 8'h00;
    localparam logic [3:0] ACC_RST    = 4'h0;
    localparam logic [3:0] MASK_RST   = 4'h0;
    localparam logic       INT_EN_RST = 1'b0;

    // ****************************************
    // Opcode patterns and match masks
    // ****************************************
    localparam logic [15:0] OPC_CLR_DIV  = 16'h1e00;
    localparam logic [15:0] OPC_CLR_EVF  = 16'h4100;
    localparam logic [15:0] OPC_CLR_PMF  = 16'h1680;
    localparam logic [15:0] OPC_CLR_PORT_CHANGE_STATUS = 16'h4400;
    localparam logic [15:0] OPC_CLR_SERIAL_PORT_STATUS = 16'h5500;
    localparam logic [15:0] OPC_CLR_WDT  = 16'h17c0;
    localparam logic [15:0] OPC_DEC      = 16'h4a80;
    localparam logic [15:0] OPC_DEC_SKIP_NONZERO    = 16'h4880;
    localparam logic [15:0] OPC_IRQ_DISABLE_OP  = 16'h50c0;
    localparam logic [15:0] OPC_EN_INT   = 16'h50e0;
    localparam logic [15:0] MSK_FULL     = 16'hffff;
    localparam logic [15:0] MSK_IMM8     = 16'hff00;
    localparam logic [15:0] MSK_IMM4     = 16'hfff0;
    localparam logic [15:0] MSK_ADDR7    = 16'hff80;

    typedef enum logic [3:0] {
        OP_NONE     = 4'h0,
        OP_CLR_DIV  = 4'h1,
        OP_CLR_EVF  = 4'h2,
        OP_CLR_PMF  = 4'h3,
        OP_CLR_PORT_CHANGE_STATUS = 4'h4,
        OP_CLR_SERIAL_PORT_STATUS = 4'h5,
        OP_CLR_WDT  = 4'h6,
        OP_DEC      = 4'h7,
        OP_IRQ_DISABLE_OP  = 4'h8,
        OP_EN_INT   = 4'h9,
        OP_DEC_SKIP_NONZERO    = 4'ha,
        OP_BAD      = 4'hb
    } op_kind_t;

    typedef struct packed {
        logic [7:0]  evFlags;
        logic        portChg;
        logic [1:0]  serStat;
        logic        wdtSlow;
        logic        intEn;
        logic [3:0]  acc;
        logic        carry;
        logic        zero;
        logic        skip;
        logic        done;
        logic        wdtExpire;
        logic [3:0]  irqSt;
        logic [3:0]  irqMask;
        logic        irq;
        logic [6:0]  memAddr;
        logic [31:0] rdata;
    } exec_state_t;
endpackage

// >>> rtl/decode_if.sv
// Carrier between the execute unit and its opcode decoder
`timescale 1ns/1ps
interface decode_if import exec_pkg::*; ();
    logic [15:0] word;
    logic        valid;
    op_kind_t    op;
    logic [7:0]  imm;
    logic [6:0]  addr;

    modport decoder (input word, input valid, output op, output imm, output addr);
    modport exec    (output word, output valid, input op, input imm, input addr);
endinterface

// >>> rtl/op_decoder.sv
// Opcode decoder for the flag-clear and decrement group
`timescale 1ns/1ps
module op_decoder import exec_pkg::*; (
    decode_if.decoder dec
);
    // Pattern match; longest fixed patterns are tested first
    always_comb begin
        dec.imm  = dec.word[7:0];
        dec.addr = dec.word[6:0];
        if (!dec.valid) begin
            dec.op = OP_NONE;
        end else if ((dec.word & MSK_FULL) == OPC_CLR_DIV) begin
            dec.op = OP_CLR_DIV;
        end else if ((dec.word & MSK_FULL) == OPC_CLR_PORT_CHANGE_STATUS) begin
            dec.op = OP_CLR_PORT_CHANGE_STATUS;
        end else if ((dec.word & MSK_FULL) == OPC_CLR_SERIAL_PORT_STATUS) begin
            dec.op = OP_CLR_SERIAL_PORT_STATUS;
        end else if ((dec.word & MSK_FULL) == OPC_CLR_WDT) begin
            dec.op = OP_CLR_WDT;
        end else if ((dec.word & MSK_FULL) == OPC_IRQ_DISABLE_OP) begin
            dec.op = OP_IRQ_DISABLE_OP;
        end else if ((dec.word & MSK_FULL) == OPC_EN_INT) begin
            dec.op = OP_EN_INT;
        end else if ((dec.word & MSK_IMM4) == OPC_CLR_PMF) begin
            dec.op = OP_CLR_PMF;
        end else if ((dec.word & MSK_ADDR7) == OPC_DEC) begin
            dec.op = OP_DEC;
        end else if ((dec.word & MSK_ADDR7) == OPC_DEC_SKIP_NONZERO) begin
            dec.op = OP_DEC_SKIP_NONZERO;
        end else if ((dec.word & MSK_IMM8) == OPC_CLR_EVF) begin
            dec.op = OP_CLR_EVF;
        end else begin
            dec.op = OP_BAD;
        end
    end
endmodule

// >>> rtl/low_clr_counter.sv
// Free counter whose lowest four bits can be cleared by an instruction
`timescale 1ns/1ps
module low_clr_counter #(
    parameter int W = 14
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         countEn,
    input  wire logic         clrLow,
    output logic [W-1:0]      value,
    output logic              wrap
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         wrap;
    } cnt_state_t;

    cnt_state_t st;
    cnt_state_t nxt;

    // Clear beats count so the low nibble lands exactly on zero
    always_comb begin
        nxt = st;
        nxt.wrap = 1'b0;
        if (clrLow) begin
            nxt.cnt = {st.cnt[W-1:4], 4'h0};
        end else if (countEn) begin
            nxt.cnt  = st.cnt + {{(W-1){1'b0}}, 1'b1};
            nxt.wrap = &st.cnt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    assign value = st.cnt;
    assign wrap  = st.wrap;

    low_nibble_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clrLow |=> (value[3:0] == 4'h0) && (value[W-1:4] == $past(value[W-1:4])))
        else $error("Low clear disturbed counter");
    count_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (countEn && !clrLow) |=> value == W'($past(value) + 1))
        else $error("Counter did not step");
endmodule

// >>> testbench/fetch_model.sv
// Behavioural fetch unit and program counter driving the execute unit
`timescale 1ns/1ps
module fetch_model (
    input  wire logic   sys_clk,
    input  wire logic   opDone,
    input  wire logic   skipNext,
    output logic        instrValid,
    output logic [15:0] instrWord,
    output logic [10:0] pc
);
    // ****************************************
    // Program counter and issue
    // ****************************************
    initial begin
        instrValid = 1'b0;
        instrWord  = 16'hffff;
        pc         = 11'h000;
    end

    // A skip request moves past the next word, otherwise one step
    always @(posedge sys_clk) begin
        if (opDone === 1'b1) begin
            pc <= pc + ((skipNext === 1'b1) ? 11'h002 : 11'h001);
        end
    end

    // One word per call; the idle word is inverted so a stale copy is never seen
    task automatic issue(input logic [15:0] w, output logic dn, output logic sk);
        @(posedge sys_clk);
        instrValid <= 1'b1;
        instrWord  <= w;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        instrWord  <= ~w;
        #1;
        dn = opDone;
        sk = skipNext;
    endtask
endmodule

// >>> testbench/flag_clear_exec_tb.sv
// Self-checking bench for the flag-clear and decrement execute unit
`timescale 1ns/1ps
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module flag_clear_exec_tb import exec_pkg::*;;
    logic        sys_clk = 1'b0;
    logic        rst_n;
    logic        instrValid;
    logic [15:0] instrWord;
    logic [7:0]  eventIn;
    logic [7:0]  busAddr;
    logic [31:0] busWrData;
    logic        busWr;
    logic        busRd;
    logic [31:0] busRdData;
    logic [3:0]  workResultReg;
    logic        carryBit;
    logic        zeroBit;
    logic        skipNext;
    logic        opDone;
    logic        intEnable;
    logic        wdtSlowClk;
    logic [7:0]  eventFlags;
    logic        portChangeStatus;
    logic [1:0]  serialPortStatus;
    logic [10:0] pc;
    logic [31:0] a;
    logic [31:0] b;
    int          miscompares = 0;
    int          checkCount = 0;

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    flag_clear_exec dut (.sys_clk(sys_clk), .rst_n(rst_n), .instrValid(instrValid),
        .instrWord(instrWord), .eventIn(eventIn), .busAddr(busAddr), .busWrData(busWrData),
        .busWr(busWr), .busRd(busRd), .busRdData(busRdData), .workResultReg(workResultReg),
        .carryBit(carryBit), .zeroBit(zeroBit), .skipNext(skipNext), .opDone(opDone),
        .intEnable(intEnable), .wdtSlowClk(wdtSlowClk), .eventFlags(eventFlags),
        .portChangeStatus(portChangeStatus), .serialPortStatus(serialPortStatus),
        .wdtExpire(), .irq());

    fetch_model fm (.sys_clk(sys_clk), .opDone(opDone), .skipNext(skipNext),
        .instrValid(instrValid), .instrWord(instrWord), .pc(pc));

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        busWr     <= 1'b1;
        busAddr   <= ad;
        busWrData <= d;
        @(posedge sys_clk);
        busWr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge sys_clk);
        busRd   <= 1'b1;
        busAddr <= ad;
        @(posedge sys_clk);
        busRd <= 1'b0;
        #1;
        d = busRdData;
    endtask

    task automatic pulse(input logic [7:0] ev);
        @(posedge sys_clk);
        eventIn <= ev;
        @(posedge sys_clk);
        eventIn <= 8'h00;
        #1;
    endtask

    // Done pulse lasts one cycle and the PC step follows the skip answer
    task automatic op(input logic [15:0] w, input logic expSkip);
        logic       dn;
        logic       sk;
        logic [10:0] pc0;
        pc0 = pc;
        fm.issue(w, dn, sk);
        `CHK(dn, 1'b1)
        `CHK(sk, expSkip)
        @(posedge sys_clk);
        #1;
        `CHK(opDone, 1'b0)
        `CHK(pc, pc0 + (expSkip ? 11'h002 : 11'h001))
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard: the tests need roughly 4400 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        rst_n = 1'b0;
        eventIn = 8'h00;
        busAddr = 8'h00;
        busWrData = 32'h0;
        busWr = 1'b0;
        busRd = 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        `CHK(intEnable, INT_EN_RST)
        rd(8'h20, a);
        `CHK(a, 32'h0)
        $display("reset test done");
        // Each mask bit drops exactly its own flag; bit 3 drops nothing
        for (int i = 0; i < 8; i++) begin
            pulse(8'hff);
            `CHK(eventFlags, EVF_VALID)
            op(OPC_CLR_EVF | (16'h0001 << i), 1'b0);
            `CHK(eventFlags, EVF_VALID & ~(8'h01 << i))
        end
        pulse(8'hff);
        op(OPC_CLR_PORT_CHANGE_STATUS, 1'b0);
        `CHK({portChangeStatus, serialPortStatus}, 3'b011)
        op(OPC_CLR_SERIAL_PORT_STATUS, 1'b0);
        `CHK(serialPortStatus, 2'b00)
        $display("flag clear test done");
        op(OPC_CLR_PMF | 16'h0008, 1'b0);
        `CHK(wdtSlowClk, 1'b1)
        op(OPC_CLR_PMF | 16'h0007, 1'b0);
        `CHK(wdtSlowClk, 1'b0)
        op(OPC_CLR_PMF | 16'h0008, 1'b0);
        // Divider keeps running, so upper bits may step by one at most
        for (int j = 0; j < 4; j++) begin
            repeat (j * 5) @(posedge sys_clk);
            rd(REG_DIV, a);
            op(OPC_CLR_DIV, 1'b0);
            rd(REG_DIV, b);
            `CHK((b[13:4] - a[13:4]) <= 10'd1 && b[3:0] <= 4'h6, 1'b1)
        end
        repeat (4200) @(posedge sys_clk);
        rd(REG_WDT, a);
        `CHK(a[3:0] != 4'h0, 1'b1)
        op(OPC_CLR_WDT, 1'b0);
        rd(REG_WDT, b);
        `CHK(b, a & 32'hfffffff0)
        $display("counter clear test done");
        wr(REG_MEM_ADDR, 32'h5);
        wr(REG_MEM_DATA, 32'h3);
        op(OPC_DEC | 16'h0005, 1'b0);
        `CHK({workResultReg, carryBit, zeroBit}, 6'b0010_00)
        rd(REG_MEM_DATA, a);
        `CHK(a, 32'h2)
        op(OPC_DEC_SKIP_NONZERO | 16'h0005, 1'b1);
        `CHK(workResultReg, 4'h1)
        op(OPC_DEC_SKIP_NONZERO | 16'h0005, 1'b0);
        `CHK({workResultReg, carryBit, zeroBit}, 6'b0000_01)
        rd(REG_IRQ_ST, a);
        wr(REG_IRQ_MASK, 32'h2);
        op(OPC_DEC | 16'h0005, 1'b0);
        `CHK({workResultReg, carryBit, zeroBit, dut.irq}, 7'b1111_101)
        rd(REG_IRQ_ST, a);
        `CHK(a, 32'h2)
        @(posedge sys_clk);
        #1;
        `CHK(dut.irq, 1'b0)
        op(16'h0000, 1'b0);
        `CHK(dut.irq, 1'b0)
        wr(REG_IRQ_MASK, 32'h8);
        @(posedge sys_clk);
        #1;
        `CHK(dut.irq, 1'b1)
        rd(REG_IRQ_ST, a);
        `CHK(a, 32'h8)
        $display("decrement and interrupt test done");
        op(OPC_EN_INT, 1'b0);
        `CHK(intEnable, 1'b1)
        op(OPC_IRQ_DISABLE_OP, 1'b0);
        `CHK(intEnable, 1'b0)
        $display("interrupt gate test done");
        tally_and_finish();
    end
endmodule
